// file: hw/supply_reset_sequencer.sv
// Supply reset sequencer: power-on, brown-out and power-up timer control
//
// Function
// R1: hold reset until supply up plus 30 us
// R2: power-on sets the power-on cause flag
// R3: brown-out comparator low forces reset at once
// R4: brown-out release waits supply plus 100 us
// R5: brown-out sets the brown-out cause flag
// R6: power-up timer delay follows extension, then release
// R7: 3-bit select picks one of eight delays
// R8: each supply rise restarts the whole delay
// R9: select-to-delay mapping is a parameter table
`timescale 1ns/1ps
module supply_reset_sequencer
  import supply_reset_pkg::*;
#(
  parameter logic [31:0] BOR_EXT_CYCLES = BOR_EXT_CYC,   // Brown-out extension count
  parameter logic [7:0][31:0] POWER_UP_TIMER_CYCLES = POWER_UP_TIMER_DEFAULT_CYC  // Power-up timer table
) (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic power_on_ok_i,       // Comparator: supply above power-on threshold
  input wire logic brown_out_low_i,     // Comparator: supply below brown-out threshold
  input wire logic [SEL_W-1:0] power_up_delay_select_i,  // From power-on config word
  input wire logic por_flag_clr_i,      // Clear strobe for power-on cause flag
  input wire logic bor_flag_clr_i,      // Clear strobe for brown-out cause flag
  output logic system_reset_line_o,     // High holds the system in reset
  output logic por_flag_o,              // Power-on cause flag
  output logic bor_flag_o               // Brown-out cause flag
);

  // ==========================================================
  // Synchronisers for the analog comparator outputs
  logic [1:0] por_sync_q;  // Stage 0 feeds stage 1 only
  logic [1:0] bor_sync_q;
  logic por_ok;            // Synchronised supply-good level
  logic bor_low;           // Synchronised brown-out level

  // Comparators are asynchronous to the core clock
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      por_sync_q <= 2'h0;
      bor_sync_q <= 2'h0;
    end else begin
      por_sync_q <= {por_sync_q[0], power_on_ok_i};
      bor_sync_q <= {bor_sync_q[0], brown_out_low_i};
    end
  end

  assign por_ok = por_sync_q[1];
  assign bor_low = bor_sync_q[1];

  // ==========================================================
  // Table lookup for the power-up timer
  function automatic logic [31:0] power_up_timer_lookup(input logic [SEL_W-1:0] sel);
    power_up_timer_lookup = POWER_UP_TIMER_CYCLES[sel];  // R9
  endfunction

  // ==========================================================
  // Sequencer state
  typedef struct packed {
    seq_state_type st;     // Sequence position
    logic start;           // Timer load strobe
    logic [31:0] load;     // Count handed to the timer
    logic sys_rst;         // Registered reset line
    logic por_flag;        // Power-on cause
    logic bor_flag;        // Brown-out cause
  } seq_type;

  localparam seq_type SEQ_RST = '{st: ST_POR_WAIT, start: 1'h0, load: 32'h0,
    sys_rst: SYS_RST_RST, por_flag: POR_FLAG_RST, bor_flag: BOR_FLAG_RST};

  seq_type s_q;
  seq_type s_d;
  delay_timer_if tif ();
  logic ext_done;          // Current timed step has run out

  // A done seen in the load cycle is stale from the previous step, so ignore it
  assign ext_done = tif.done && !s_q.start;

  // Next-state logic
  always_comb begin
    s_d = s_q;
    s_d.start = 1'h0;
    // Clear strobes act first so that a same-cycle event still sets the flag
    if (por_flag_clr_i) begin
      s_d.por_flag = 1'h0;
    end
    if (bor_flag_clr_i) begin
      s_d.bor_flag = 1'h0;
    end
    if (!por_ok) begin
      // Supply under power-on threshold: start over
      s_d.st = ST_POR_WAIT;
      s_d.por_flag = 1'h1;  // R2
    end else if (bor_low) begin
      // Brown-out overrides any step, including the power-up timer
      s_d.st = ST_BOR_HOLD;  // R3
      if (s_q.st != ST_BOR_HOLD) begin
        s_d.bor_flag = 1'h1;  // R5
      end
    end else begin
      case (s_q.st)
        // Supply just crossed the power-on threshold
        ST_POR_WAIT: begin
          s_d.st = ST_POR_EXT;  // R1
          s_d.start = 1'h1;
          s_d.load = POR_EXT_CYC;
        end
        // Bias settling time
        ST_POR_EXT: begin
          if (ext_done) begin
            s_d.st = ST_POWER_UP_TIMER;  // R6
            s_d.start = 1'h1;
            s_d.load = power_up_timer_lookup(power_up_delay_select_i);  // R7
          end
        end
        // Supply back over brown-out threshold: full delay restarts
        ST_BOR_HOLD: begin
          s_d.st = ST_BOR_EXT;  // R4 R8
          s_d.start = 1'h1;
          s_d.load = BOR_EXT_CYCLES;
        end
        // Regulator settling time
        ST_BOR_EXT: begin
          if (ext_done) begin
            s_d.st = ST_POWER_UP_TIMER;  // R6
            s_d.start = 1'h1;
            s_d.load = power_up_timer_lookup(power_up_delay_select_i);  // R7
          end
        end
        // Power-up timer, last step before release
        ST_POWER_UP_TIMER: begin
          if (ext_done) begin
            s_d.st = ST_RUN;  // R6
          end
        end
        ST_RUN: begin
          s_d.st = ST_RUN;
        end
        default: begin
          s_d.st = ST_POR_WAIT;
        end
      endcase
    end
    // Reset line follows the next state so it is a clean flop output
    s_d.sys_rst = (s_d.st != ST_RUN);  // R1 R3 R4 R6
  end

  // Register the state
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_q <= SEQ_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Timer and outputs
  assign tif.start = s_q.start;
  assign tif.load = s_q.load;

  delay_timer u_timer (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .tif(tif.tmr)
  );

  assign system_reset_line_o = s_q.sys_rst;
  assign por_flag_o = s_q.por_flag;
  assign bor_flag_o = s_q.bor_flag;

  // ==========================================================
  // Checks
  seq_state_type st_q;
  logic [31:0] power_up_timer_exp;
  assign st_q = s_q.st;
  assign power_up_timer_exp = power_up_timer_lookup(power_up_delay_select_i);

  sequence power_up_timer_run_out;
    (st_q == ST_POWER_UP_TIMER) && ext_done;
  endsequence

  sequence supply_good;
    por_ok && !bor_low;
  endsequence

  por_ext_start_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)  // R1
    $rose(st_q == ST_POR_EXT) |-> s_q.start && (s_q.load == POR_EXT_CYC))
    else $error("power-on extension not started");

  por_flag_set_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)  // R2
    !por_ok |=> por_flag_o)
    else $error("power-on flag not set");

  bor_hold_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)  // R3
    por_ok && bor_low |=> (st_q == ST_BOR_HOLD) && system_reset_line_o)
    else $error("brown-out did not hold reset");

  bor_ext_load_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)  // R4
    $rose(st_q == ST_BOR_EXT) |-> $past(st_q) == ST_BOR_HOLD && s_q.start
      && (s_q.load == BOR_EXT_CYCLES))
    else $error("brown-out extension not started");

  bor_flag_set_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)  // R5
    $rose(st_q == ST_BOR_HOLD) |-> bor_flag_o)
    else $error("brown-out flag not set");

  release_order_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)  // R6
    $fell(system_reset_line_o) |-> $past(st_q) == ST_POWER_UP_TIMER)
    else $error("reset released outside power-up timer");

  power_up_timer_release_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)  // R6
    power_up_timer_run_out ##0 supply_good |=> !system_reset_line_o)
    else $error("reset not released after power-up timer");

  power_up_timer_select_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)  // R7
    $rose(st_q == ST_POWER_UP_TIMER) |-> s_q.load == $past(power_up_timer_exp))
    else $error("power-up delay not taken from select");

  // A dip in mid-extension must drop back to hold, and the next extension starts full
  bor_restart_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)  // R8
    (st_q == ST_BOR_EXT) ##0 supply_good ##1 (bor_low && por_ok)
      |=> (st_q == ST_BOR_HOLD)
      ##1 ((st_q != ST_BOR_EXT) || (s_q.start && (s_q.load == BOR_EXT_CYCLES))))
    else $error("brown-out delay did not restart");

endmodule // supply_reset_sequencer

// file: hw/supply_reset_pkg.sv
// Constants, states and timing counts for the supply reset sequencer
package supply_reset_pkg;

  // ==========================================================
  // Clock and time units
  localparam int unsigned CLK_PERIOD_NS = 10;         // 100 MHz core clock
  localparam int unsigned MS_NS = 1000000;            // One millisecond in ns
  localparam int unsigned CYC_PER_MS = MS_NS / CLK_PERIOD_NS;

  // ==========================================================
  // Extension delays (longest times, rounded down to whole cycles)
  localparam int unsigned POR_EXT_NS = 30000;         // Power-on extension, 30 us
  localparam int unsigned BOR_EXT_NS = 100000;        // Brown-out extension, 100 us
  localparam logic [31:0] POR_EXT_CYC = 32'(POR_EXT_NS / CLK_PERIOD_NS);
  localparam logic [31:0] BOR_EXT_CYC = 32'(BOR_EXT_NS / CLK_PERIOD_NS);

  // ==========================================================
  // Power-up timer table, one entry per select code, in cycles
  localparam int unsigned SEL_W = 3;                  // Width of delay select
  localparam logic [7:0][31:0] POWER_UP_TIMER_DEFAULT_CYC = {
    32'(32'h80 * CYC_PER_MS), 32'(32'h40 * CYC_PER_MS),
    32'(32'h20 * CYC_PER_MS), 32'(32'h10 * CYC_PER_MS),
    32'(32'h08 * CYC_PER_MS), 32'(32'h04 * CYC_PER_MS),
    32'(32'h02 * CYC_PER_MS), 32'h0000_0000};

  // ==========================================================
  // Reset values
  localparam logic POR_FLAG_RST = 1'h1;               // Power-on is the reset cause
  localparam logic BOR_FLAG_RST = 1'h0;
  localparam logic SYS_RST_RST = 1'h1;                // Held in reset from power-on

  // Sequencer states
  typedef enum logic [2:0] {
    ST_POR_WAIT, ST_POR_EXT, ST_BOR_HOLD, ST_BOR_EXT, ST_POWER_UP_TIMER, ST_RUN
  } seq_state_type;

endpackage

// file: hw/delay_timer_if.sv
// Start, load and done signals between the sequencer and its delay timer
`timescale 1ns/1ps
interface delay_timer_if;
  logic start;          // One-cycle load strobe
  logic [31:0] load;    // Cycles to wait
  logic done;           // Level: programmed wait has run out

  modport ctrl (output start, output load, input done);
  modport tmr (input start, input load, output done);
endinterface // delay_timer_if

// file: hw/delay_timer.sv
// Down-counting delay timer, restarted on every start strobe
`timescale 1ns/1ps
module delay_timer (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  delay_timer_if.tmr tif
);

  // ==========================================================
  // State
  typedef struct packed {
    logic run;          // Timer armed
    logic [31:0] cnt;   // Cycles left
  } tmr_state_type;

  tmr_state_type s_q;
  tmr_state_type s_d;

  // Next state: a start always reloads, so a new delay restarts from the top
  always_comb begin
    s_d = s_q;
    if (tif.start) begin
      s_d.run = 1'h1;
      s_d.cnt = tif.load;
    end else if (s_q.run && (s_q.cnt != 32'h0)) begin
      s_d.cnt = s_q.cnt - 32'h1;
    end
  end

  // Register the state
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Done once armed and drained
  assign tif.done = s_q.run && (s_q.cnt == 32'h0);

  // ==========================================================
  // Checks
  timer_load_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    tif.start |=> (s_q.cnt == $past(tif.load)) && s_q.run)
    else $error("timer did not load its count");

endmodule // delay_timer

// file: test/supply_reset_sequencer_bench.sv
// Self-checking bench for the supply reset sequencer
`timescale 1ns/1ps
module supply_reset_sequencer_bench;
  import supply_reset_pkg::*;
  // ==========================================================
  // Setup
  // Short brown-out and table counts keep the run brief; expectations derive from them and the package POR_EXT_CYC
  localparam logic [31:0] BOR_EXT = 32'h0000_0032;
  localparam logic [7:0][31:0] POWER_UP_TIMER_TAB = {32'h23, 32'h1e, 32'h19, 32'h14,
    32'h0f, 32'h0a, 32'h05, 32'h00};
  localparam int POR_EXT = int'(POR_EXT_CYC); // Power-on extension in cycles, from the package
  localparam int SLACK = 16; // Sync flops plus sequencing overhead
  logic mclk_i;
  logic arst_n_i;
  logic power_on_ok_i;
  logic brown_out_low_i;
  logic [SEL_W-1:0] sel;
  logic por_clr;
  logic bor_clr;
  logic sys_rst;
  logic por_flag;
  logic bor_flag;
  int n_fail;
  int checks;
  int n;
  logic [31:0] rng;

  supply_reset_sequencer #(.BOR_EXT_CYCLES(BOR_EXT), .POWER_UP_TIMER_CYCLES(POWER_UP_TIMER_TAB)) u_dut (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .power_on_ok_i(power_on_ok_i),
    .brown_out_low_i(brown_out_low_i), .power_up_delay_select_i(sel),
    .por_flag_clr_i(por_clr), .bor_flag_clr_i(bor_clr),
    .system_reset_line_o(sys_rst), .por_flag_o(por_flag), .bor_flag_o(bor_flag));

  // 100 MHz clock
  initial begin
    mclk_i = 1'h0;
    forever #5 mclk_i = ~mclk_i;
  end

  // ==========================================================
  // Helpers
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // Expected release delay: extension count plus the selected power-up count
  function automatic int exp_delay(input int ext, input logic [SEL_W-1:0] s);
    return ext + int'(POWER_UP_TIMER_TAB[s]);
  endfunction

  // Compare one flag or line level
  task automatic check_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Compare a measured delay against its window
  task automatic check_win(input int got, input int lo);
    checks++;
    if (got < lo || got > lo + SLACK) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, lo);
    end
  endtask

  // Count edges until the reset line drops; bounded so a hang ends
  task automatic wait_release(output int cnt);
    cnt = 0;
    while (sys_rst !== 1'h0 && cnt < 20000) begin
      @(posedge mclk_i);
      #1;
      cnt++;
    end
  endtask

  task automatic edges(input int k);
    repeat (k) @(posedge mclk_i);
    #1;
  endtask

  // Pulse both flag clears for one cycle
  task automatic clear_flags();
    por_clr = 1'h1;
    bor_clr = 1'h1;
    edges(1);
    por_clr = 1'h0;
    bor_clr = 1'h0;
    edges(1);
  endtask

  task automatic complete_run();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Watchdog: the whole run needs well under 20000 cycles
  initial begin
    repeat (40000) @(posedge mclk_i);
    n_fail++;
    $display("[FAIL] t=%0t watchdog got=%h exp=%h", $time, 1'h1, 1'h0);
    complete_run();
  end

  // ==========================================================
  // Tests
  initial begin
    n_fail = 0;
    checks = 0;
    rng = 32'h0001_0024;
    arst_n_i = 1'h0;
    power_on_ok_i = 1'h0;
    brown_out_low_i = 1'h0;
    sel = 3'h0;
    por_clr = 1'h0;
    bor_clr = 1'h0;
    edges(6);
    arst_n_i = 1'h1;
    check_bit(sys_rst, 1'h1);
    check_bit(por_flag, 1'h1);
    check_bit(bor_flag, 1'h0);
    // Supply still low: reset must hold however long we wait
    rng = xorshift(rng);
    edges(10 + int'(rng[5:0]));
    check_bit(sys_rst, 1'h1);
    $display("test reset values done");
    // Power-on with a random delay code
    rng = xorshift(rng);
    sel = rng[2:0];
    power_on_ok_i = 1'h1;
    wait_release(n);
    check_win(n, exp_delay(POR_EXT, sel));
    check_bit(bor_flag, 1'h0);
    clear_flags();
    check_bit(por_flag, 1'h0);
    $display("test power-on done");
    // Brown-out through every delay code, random low time
    for (int i = 0; i < 8; i++) begin
      sel = i[2:0];
      brown_out_low_i = 1'h1;
      edges(4);
      check_bit(sys_rst, 1'h1);
      check_bit(bor_flag, 1'h1);
      rng = xorshift(rng);
      edges(1 + int'(rng[4:0]));
      check_bit(sys_rst, 1'h1);
      brown_out_low_i = 1'h0;
      wait_release(n);
      check_win(n, exp_delay(int'(BOR_EXT), sel));
      check_bit(por_flag, 1'h0);
      clear_flags();
      check_bit(bor_flag, 1'h0);
    end
    $display("test brown-out codes done");
    // Second dip in mid-extension restarts the whole delay
    sel = 3'h6;
    brown_out_low_i = 1'h1;
    edges(6);
    brown_out_low_i = 1'h0;
    edges(30);
    check_bit(sys_rst, 1'h1);
    brown_out_low_i = 1'h1;
    edges(5);
    brown_out_low_i = 1'h0;
    wait_release(n);
    check_win(n, exp_delay(int'(BOR_EXT), sel));
    clear_flags();
    $display("test restart done");
    // Supply drop while running goes back through power-on
    // Clear held across the drop: once the drop is seen the set must win
    power_on_ok_i = 1'h0;
    por_clr = 1'h1;
    edges(4);
    check_bit(sys_rst, 1'h1);
    check_bit(por_flag, 1'h1);
    por_clr = 1'h0;
    sel = 3'h7;
    power_on_ok_i = 1'h1;
    wait_release(n);
    check_win(n, exp_delay(POR_EXT, sel));
    $display("test supply drop done");
    complete_run();
  end
endmodule // supply_reset_sequencer_bench
